// ==== hw/ppc_params.svh ====
// constants for the port pin cell controller
`ifndef PPC_PARAMS_SVH
`define PPC_PARAMS_SVH
`define PPC_ADDR_P0_LATCH   8'h00
`define PPC_ADDR_P0_INMODE  8'h04
`define PPC_ADDR_P0_OUTMODE 8'h08
`define PPC_ADDR_P1_LATCH   8'h0c
`define PPC_ADDR_P1_INMODE  8'h10
`define PPC_ADDR_P1_OUTMODE 8'h14
`define PPC_ADDR_P2_LATCH   8'h18
`define PPC_ADDR_P2_OUTMODE 8'h1c
`define PPC_ADDR_CONTROL    8'h20
`define PPC_ADDR_P0_PAD     8'h24
`define PPC_ADDR_P1_PAD     8'h28
`define PPC_ADDR_P2_PAD     8'h2c
`define PPC_CTRL_XBAR_BIT   0
`define PPC_CTRL_WPUD_BIT   1
`define PPC_RST_LATCH       8'hff
`define PPC_RST_INMODE      8'hff
`define PPC_RST_OUTMODE     8'h00
`define PPC_RESP_OKAY       2'b00
`define PPC_RESP_SLVERR     2'b10
`endif

// ==== hw/ppc_pkg.sv ====
// types shared by the port pin cell controller
package ppc_pkg;
    // one pad's drive controls
    typedef struct packed {
        logic highOn;
        logic lowOn;
        logic pullOn;
        logic rxOn;
    } ppc_drive_s;
    typedef enum logic [1:0] {
        PPC_W_IDLE,
        PPC_W_RESP
    } ppc_wstate_e;
endpackage

// ==== hw/ppc_pin_cell.sv ====
// one port pin cell: drivers, pull-up and read-back
module ppc_pin_cell (
    input  wire logic               latchBit,
    input  wire logic               inMode,
    input  wire logic               outMode,
    input  wire logic               xbarOn,
    input  wire logic               periphSel,
    input  wire logic               periphVal,
    input  wire logic               pullDisable,
    input  wire logic               padSync,
    output ppc_pkg::ppc_drive_s     drive,
    output logic                    readBit
);
    import ppc_pkg::*;
    // value the pin wants to show
    wire outVal = periphSel ? periphVal : latchBit;
    wire digital = inMode;
    // push-pull drives high on 1, open-drain never does
    wire wantHigh = digital & xbarOn & outMode & outVal;
    wire wantLow  = digital & xbarOn & ~outVal;
    // pull-up only when digital, not driven low, not globally off
    wire wantPull = digital & ~wantLow & ~pullDisable;
    assign drive.highOn = wantHigh;
    assign drive.lowOn  = wantLow;
    assign drive.pullOn = wantPull;
    assign drive.rxOn   = digital;
    // pad level when digital, zero when analog
    assign readBit = digital & padSync;
endmodule

// ==== hw/ppc_port_cfg.sv ====
// port pin cell controller with an axi4-lite register slave
module ppc_port_cfg (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               clkEn,
    // axi4-lite slave
    input  wire logic [7:0]         awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    input  wire logic [7:0]         araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    // crossbar peripheral routing
    input  wire logic [16:0]        periphSel,
    input  wire logic [16:0]        periphVal,
    // pads: input level, drive enables, pull-up
    input  wire logic [16:0]        padIn,
    output logic [16:0]             padOut,
    output logic [16:0]             padOe,
    output logic [16:0]             padPullEn,
    output logic [16:0]             padRxEn,
    // extra pin is shared with the debug wire
    input  wire logic               debugActive,
    input  wire logic               debugWireDataOut,
    input  wire logic               debugWireDataOe,
    output logic                    debugWireDataIn
);
    import ppc_pkg::*;
    `include "ppc_params.svh"

    // reset release through two flops
    logic rstMeta_q;
    logic rstSync_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end
    wire rstN = rstSync_q;

    // configuration registers
    logic [7:0]  p0Latch_q;
    logic [7:0]  p0InMode_q;
    logic [7:0]  p0OutMode_q;
    logic [7:0]  p1Latch_q;
    logic [7:0]  p1InMode_q;
    logic [7:0]  p1OutMode_q;
    logic        p2Latch_q;
    logic        p2OutMode_q;
    logic        xbarEnable_q;
    logic        pullupDisable_q;

    // pad input synchronisers
    logic [16:0] padMeta_q;
    logic [16:0] padSync_q;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            padMeta_q <= 17'h00000;
            padSync_q <= 17'h00000;
        end else if (clkEn) begin
            padMeta_q <= padIn;
            padSync_q <= padMeta_q;
        end
    end

    // write channel: hold address and data until both seen
    ppc_wstate_e wState_q;
    logic        awHeld_q;
    logic        wHeld_q;
    logic [7:0]  wAddr_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    wire awTake  = awvalid & awready;
    wire wTake   = wvalid & wready;
    wire haveAw  = awHeld_q | awTake;
    wire haveW   = wHeld_q | wTake;
    wire [7:0]  curWAddr = awTake ? awaddr : wAddr_q;
    wire [31:0] curWData = wTake ? wdata : wData_q;
    wire [3:0]  curWStrb = wTake ? wstrb : wStrb_q;
    wire doWrite = (wState_q == PPC_W_IDLE) & haveAw & haveW & clkEn;
    wire wrByte  = curWStrb[0];
    wire wMapped = (curWAddr <= `PPC_ADDR_CONTROL) & (curWAddr[1:0] == 2'b00);

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            wState_q <= PPC_W_IDLE;
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            wAddr_q  <= 8'h00;
            wData_q  <= 32'h00000000;
            wStrb_q  <= 4'h0;
            awready  <= 1'b0;
            wready   <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= `PPC_RESP_OKAY;
        end else if (clkEn) begin
            unique case (wState_q)
                PPC_W_IDLE: begin
                    if (doWrite) begin
                        awHeld_q <= 1'b0;
                        wHeld_q  <= 1'b0;
                        awready  <= 1'b0;
                        wready   <= 1'b0;
                        bvalid   <= 1'b1;
                        bresp    <= wMapped ? `PPC_RESP_OKAY : `PPC_RESP_SLVERR;
                        wState_q <= PPC_W_RESP;
                    end else begin
                        if (awTake) begin
                            awHeld_q <= 1'b1;
                            wAddr_q  <= awaddr;
                        end
                        if (wTake) begin
                            wHeld_q <= 1'b1;
                            wData_q <= wdata;
                            wStrb_q <= wstrb;
                        end
                        awready <= ~(awHeld_q | awTake);
                        wready  <= ~(wHeld_q | wTake);
                    end
                end
                PPC_W_RESP: begin
                    if (bready) begin
                        bvalid   <= 1'b0;
                        awready  <= 1'b1;
                        wready   <= 1'b1;
                        wState_q <= PPC_W_IDLE;
                    end
                end
            endcase
        end
    end

    // register file update, low byte lane only
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            p0Latch_q       <= `PPC_RST_LATCH;
            p0InMode_q      <= `PPC_RST_INMODE;
            p0OutMode_q     <= `PPC_RST_OUTMODE;
            p1Latch_q       <= `PPC_RST_LATCH;
            p1InMode_q      <= `PPC_RST_INMODE;
            p1OutMode_q     <= `PPC_RST_OUTMODE;
            p2Latch_q       <= 1'b1;
            p2OutMode_q     <= 1'b0;
            xbarEnable_q    <= 1'b0;
            pullupDisable_q <= 1'b0;
        end else if (doWrite && wrByte) begin
            unique case (curWAddr)
                `PPC_ADDR_P0_LATCH:   p0Latch_q   <= curWData[7:0];
                `PPC_ADDR_P0_INMODE:  p0InMode_q  <= curWData[7:0];
                `PPC_ADDR_P0_OUTMODE: p0OutMode_q <= curWData[7:0];
                `PPC_ADDR_P1_LATCH:   p1Latch_q   <= curWData[7:0];
                `PPC_ADDR_P1_INMODE:  p1InMode_q  <= curWData[7:0];
                `PPC_ADDR_P1_OUTMODE: p1OutMode_q <= curWData[7:0];
                `PPC_ADDR_P2_LATCH:   p2Latch_q   <= curWData[0];
                `PPC_ADDR_P2_OUTMODE: p2OutMode_q <= curWData[0];
                `PPC_ADDR_CONTROL: begin
                    xbarEnable_q    <= curWData[`PPC_CTRL_XBAR_BIT];
                    pullupDisable_q <= curWData[`PPC_CTRL_WPUD_BIT];
                end
                default: ;
            endcase
        end
    end

    // per-pin vectors; the extra pin is always digital
    wire [16:0] latchVec   = {p2Latch_q, p1Latch_q, p0Latch_q};
    wire [16:0] inModeVec  = {1'b1, p1InMode_q, p0InMode_q};
    wire [16:0] outModeVec = {p2OutMode_q, p1OutMode_q, p0OutMode_q};
    ppc_drive_s [16:0] driveVec;
    wire [16:0] readVec;

    // one cell per pin
    genvar gi;
    generate
        for (gi = 0; gi < 17; gi++) begin : gPin
            ppc_pin_cell uCell (
                .latchBit    (latchVec[gi]),
                .inMode      (inModeVec[gi]),
                .outMode     (outModeVec[gi]),
                .xbarOn      (xbarEnable_q),
                .periphSel   (periphSel[gi]),
                .periphVal   (periphVal[gi]),
                .pullDisable (pullupDisable_q),
                .padSync     (padSync_q[gi]),
                .drive       (driveVec[gi]),
                .readBit     (readVec[gi])
            );
        end
    endgenerate

    // pad outputs; debug wire overrides the extra pin while active
    logic [16:0] padOutD;
    logic [16:0] padOeD;
    logic [16:0] padPullD;
    logic [16:0] padRxD;
    always_comb begin
        for (int i = 0; i < 17; i++) begin
            padOutD[i]  = driveVec[i].highOn;
            padOeD[i]   = driveVec[i].highOn | driveVec[i].lowOn;
            padPullD[i] = driveVec[i].pullOn;
            padRxD[i]   = driveVec[i].rxOn;
        end
        if (debugActive) begin
            padOutD[16]  = debugWireDataOut;
            padOeD[16]   = debugWireDataOe;
            padPullD[16] = ~debugWireDataOe & ~pullupDisable_q;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            padOut          <= 17'h00000;
            padOe           <= 17'h00000;
            padPullEn       <= 17'h1ffff;
            padRxEn         <= 17'h1ffff;
            debugWireDataIn <= 1'b0;
        end else if (clkEn) begin
            padOut          <= padOutD;
            padOe           <= padOeD;
            padPullEn       <= padPullD;
            padRxEn         <= padRxD;
            debugWireDataIn <= padSync_q[16];
        end
    end

    // read decode
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h00000000;
        unique case (araddr)
            `PPC_ADDR_P0_LATCH:   rdMux[7:0] = p0Latch_q;
            `PPC_ADDR_P0_INMODE:  rdMux[7:0] = p0InMode_q;
            `PPC_ADDR_P0_OUTMODE: rdMux[7:0] = p0OutMode_q;
            `PPC_ADDR_P1_LATCH:   rdMux[7:0] = p1Latch_q;
            `PPC_ADDR_P1_INMODE:  rdMux[7:0] = p1InMode_q;
            `PPC_ADDR_P1_OUTMODE: rdMux[7:0] = p1OutMode_q;
            `PPC_ADDR_P2_LATCH:   rdMux[0]   = p2Latch_q;
            `PPC_ADDR_P2_OUTMODE: rdMux[0]   = p2OutMode_q;
            `PPC_ADDR_CONTROL: begin
                rdMux[`PPC_CTRL_XBAR_BIT] = xbarEnable_q;
                rdMux[`PPC_CTRL_WPUD_BIT] = pullupDisable_q;
            end
            `PPC_ADDR_P0_PAD:     rdMux[7:0] = readVec[7:0];
            `PPC_ADDR_P1_PAD:     rdMux[7:0] = readVec[15:8];
            `PPC_ADDR_P2_PAD:     rdMux[0]   = readVec[16];
            default: ;
        endcase
    end
    wire rMapped = (araddr <= `PPC_ADDR_P2_PAD) & (araddr[1:0] == 2'b00);

    // read channel: take address, answer next cycle
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= `PPC_RESP_OKAY;
        end else if (clkEn) begin
            if (rvalid) begin
                if (rready) begin
                    rvalid  <= 1'b0;
                    arready <= 1'b1;
                end
            end else if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= rdMux;
                rresp   <= rMapped ? `PPC_RESP_OKAY : `PPC_RESP_SLVERR;
            end else begin
                arready <= 1'b1;
            end
        end
    end
endmodule

// ==== bench/ppc_port_cfg_sva.sv ====
// assertion checker for the port pin cell controller
module ppc_port_cfg_sva (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        clkEn,
    input wire logic        awready,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [16:0] padIn,
    input wire logic [16:0] padOut,
    input wire logic [16:0] padOe,
    input wire logic [16:0] padPullEn,
    input wire logic [16:0] padRxEn,
    input wire logic        debugWireDataIn
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // pad cell relations
    chk_reset_idle: assert property ($rose(nrst) |-> padOe == 17'h0 && padPullEn == 17'h1ffff)
        else $error("pads not idle at reset release");
    chk_analog_quiet: assert property (((padOe | padPullEn) & ~padRxEn) == 17'h0)
        else $error("analog pin drives or pulls");
    chk_low_no_pull: assert property ((padPullEn & padOe & ~padOut) == 17'h0)
        else $error("pull-up on while driving low");
    chk_extra_digital: assert property (padRxEn[16] == 1'b1)
        else $error("extra pin left digital mode");
    chk_sync_level: assert property ((clkEn && $stable(padIn[16]))[*8] |->
        debugWireDataIn == padIn[16]) else $error("extra pin level not followed");
    // register bus handshakes
    chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    chk_ar_block: assert property (rvalid |-> !arready)
        else $error("read accepted while answer pending");
    chk_w_block: assert property (bvalid |-> !awready && !wready)
        else $error("write accepted while response pending");
endmodule

bind ppc_port_cfg ppc_port_cfg_sva chk_u (.clk, .nrst, .clkEn, .awready, .wready, .bresp,
    .bvalid, .bready, .arready, .rdata, .rvalid, .rready, .padIn, .padOut, .padOe,
    .padPullEn, .padRxEn, .debugWireDataIn);

// ==== bench/ppc_board_model.sv ====
// board model: resolves each pad from cell drive, pull-up and outside drivers
module ppc_board_model (
    input  wire logic        clk,
    input  wire logic [16:0] padOut,
    input  wire logic [16:0] padOe,
    input  wire logic [16:0] padPullEn,
    input  wire logic [16:0] extDrive,
    input  wire logic [16:0] extVal,
    output logic      [16:0] padIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flt = 1'b0;
    // a pad nobody drives or pulls wanders every cycle
    always @(posedge clk) flt <= ~flt;
    assign padIn = (padOe & padOut) | (~padOe & extDrive & extVal)
                 | (~padOe & ~extDrive & (padPullEn | {17{flt}}));
endmodule

// ==== bench/ppc_port_cfg_tb.sv ====
// self-checking bench for the port pin cell controller
`include "ppc_params.svh"
module ppc_port_cfg_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, clkEn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
    logic awready, wready, arready, debugActive, debugWireDataOut, debugWireDataOe;
    logic debugWireDataIn;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [16:0] periphSel, periphVal, padIn, padOut, padOe, padPullEn, padRxEn;
    logic [16:0] extDrive, extVal;
    int errorCnt = 0;
    int testsRun = 0;
    // cycles that bready or rready is held back, so the slave must keep its answer
    int hold = 0;

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ppc_port_cfg dut_u (.clk, .nrst, .clkEn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .periphSel, .periphVal, .padIn, .padOut, .padOe,
        .padPullEn, .padRxEn, .debugActive, .debugWireDataOut, .debugWireDataOe,
        .debugWireDataIn);
    ppc_board_model board_u (.clk, .padOut, .padOe, .padPullEn, .extDrive, .extVal, .padIn);

    task endSim;
        if (errorCnt == 0 && testsRun > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        testsRun++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            errorCnt++;
        end
    endtask

    // one write: address and data offered together, response awaited
    task axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= (hold == 0);
        n = 0;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            n++;
            if (n >= hold && bready !== 1'b1) bready <= 1'b1;
        end while (!(bvalid === 1'b1 && bready === 1'b1) && n < 50);
        if (n >= 50) begin
            errorCnt++;
            endSim;
        end
        bready <= 1'b0;
        cmp("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    // one read with expected data and response
    task axiRd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= (hold == 0);
        n = 0;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            n++;
            if (n >= hold && rready !== 1'b1) rready <= 1'b1;
        end while (!(rvalid === 1'b1 && rready === 1'b1) && n < 50);
        if (n >= 50) begin
            errorCnt++;
            endSim;
        end
        rready <= 1'b0;
        cmp("rdata", ed, rdata);
        cmp("rresp", {30'h0, er}, {30'h0, rresp});
    endtask

    // let pads settle, then check drive enables, driven value and pull-ups
    task pads(input logic [16:0] oe, input logic [16:0] drv, input logic [16:0] pull);
        repeat (4) @(posedge clk);
        cmp("padOe", {15'h0, oe}, {15'h0, padOe});
        cmp("padOut", {15'h0, drv}, {15'h0, padOut & padOe});
        cmp("padPullEn", {15'h0, pull}, {15'h0, padPullEn});
    endtask

    initial begin
        {nrst, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        {periphSel, periphVal, extDrive, extVal} = '0;
        {debugActive, debugWireDataOut, debugWireDataOe} = '0;
        clkEn = 1'b1;
        wstrb = 4'hf;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (5) @(posedge clk);
        pads(17'h0, 17'h0, 17'h1ffff);
        cmp("padRxEn", 32'h1ffff, {15'h0, padRxEn});
        axiRd(`PPC_ADDR_P0_LATCH, 32'hff, `PPC_RESP_OKAY);
        axiRd(`PPC_ADDR_P1_INMODE, 32'hff, `PPC_RESP_OKAY);
        axiRd(`PPC_ADDR_P0_OUTMODE, 32'h0, `PPC_RESP_OKAY);
        axiRd(`PPC_ADDR_CONTROL, 32'h0, `PPC_RESP_OKAY);
        axiWr(`PPC_ADDR_P0_LATCH, 32'h0, `PPC_RESP_OKAY);
        axiWr(`PPC_ADDR_P0_OUTMODE, 32'hff, `PPC_RESP_OKAY);
        pads(17'h0, 17'h0, 17'h1ffff);
        axiWr(`PPC_ADDR_CONTROL, 32'h1, `PPC_RESP_OKAY);
        pads(17'h000ff, 17'h0, 17'h1ff00);
        axiWr(`PPC_ADDR_P0_LATCH, 32'h5a, `PPC_RESP_OKAY);
        pads(17'h000ff, 17'h0005a, 17'h1ff5a);
        axiRd(`PPC_ADDR_P0_PAD, 32'h5a, `PPC_RESP_OKAY);
        extDrive <= 17'h00f00;
        axiWr(`PPC_ADDR_P1_LATCH, 32'h0f, `PPC_RESP_OKAY);
        pads(17'h0f0ff, 17'h0005a, 17'h10f5a);
        axiRd(`PPC_ADDR_P1_PAD, 32'h0, `PPC_RESP_OKAY);
        axiWr(`PPC_ADDR_P0_LATCH, 32'hff, `PPC_RESP_OKAY);
        extDrive <= 17'h00f0f;
        extVal <= 17'h0000f;
        axiWr(`PPC_ADDR_P0_INMODE, 32'hf0, `PPC_RESP_OKAY);
        pads(17'h0f0f0, 17'h000f0, 17'h10ff0);
        cmp("padRxEn", 32'h1fff0, {15'h0, padRxEn});
        axiRd(`PPC_ADDR_P0_PAD, 32'hf0, `PPC_RESP_OKAY);
        periphSel <= 17'h00100;
        axiWr(`PPC_ADDR_CONTROL, 32'h3, `PPC_RESP_OKAY);
        pads(17'h0f1f0, 17'h000f0, 17'h0);
        axiWr(`PPC_ADDR_CONTROL, 32'h0, `PPC_RESP_OKAY);
        pads(17'h0, 17'h0, 17'h1fff0);
        axiRd(`PPC_ADDR_P1_PAD, 32'hf0, `PPC_RESP_OKAY);
        debugActive <= 1'b1;
        debugWireDataOe <= 1'b1;
        pads(17'h10000, 17'h0, 17'h0fff0);
        repeat (4) @(posedge clk);
        cmp("debugWireDataIn", 32'h0, {31'h0, debugWireDataIn});
        debugActive <= 1'b0;
        axiWr(`PPC_ADDR_CONTROL, 32'h1, `PPC_RESP_OKAY);
        axiWr(`PPC_ADDR_P2_OUTMODE, 32'h1, `PPC_RESP_OKAY);
        axiWr(`PPC_ADDR_P2_LATCH, 32'h0, `PPC_RESP_OKAY);
        pads(17'h1f1f0, 17'h000f0, 17'h00ef0);
        axiRd(`PPC_ADDR_P2_PAD, 32'h0, `PPC_RESP_OKAY);
        hold = 3;
        axiWr(`PPC_ADDR_P2_LATCH, 32'h1, `PPC_RESP_OKAY);
        repeat (4) @(posedge clk);
        axiRd(`PPC_ADDR_P2_PAD, 32'h1, `PPC_RESP_OKAY);
        hold = 0;
        // clock enable low freezes the pads although the peripheral value moves
        clkEn <= 1'b0;
        periphVal <= 17'h00100;
        repeat (4) @(posedge clk);
        cmp("padOe", 32'h1f1f0, {15'h0, padOe});
        clkEn <= 1'b1;
        pads(17'h1f0f0, 17'h100f0, 17'h10ff0);
        // unmapped and read-only places are refused
        axiWr(8'h30, 32'h0, `PPC_RESP_SLVERR);
        axiWr(`PPC_ADDR_P0_PAD, 32'h0, `PPC_RESP_SLVERR);
        axiRd(8'h30, 32'h0, `PPC_RESP_SLVERR);
        endSim;
    end
endmodule
